// [rtl/cei_pkg.sv]
// Behaviour
// - Rising-edge enable set: each low-to-high result transition sets the interrupt flag.
// - Falling-edge enable set: each high-to-low result transition sets the interrupt flag.
// - Cleared enable blocks its edge direction; both cleared, no edge sets flag.
// - Positive select 00 pin, 01 DAC reference, 10 fixed reference, 11 ground.
// - Negative select 0 routes first negative pin, 1 the second.
// - Control bits 3..1 read zero and ignore writes.
package cei_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [31:0] CTRL_ONE_ADDR = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
    localparam int RISE_BIT = 7;
    localparam int FALL_BIT = 6;
    localparam int POS_SEL_LO = 4;
    localparam int NEG_SEL_BIT = 0;
    localparam logic [7:0] CTRL_WR_MASK = 8'hF1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_RESULT_BIT = 1;
    // ----------------------------------------
    // Input routing codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        POS_PIN = 2'h0,
        POS_DAC = 2'h1,
        POS_FIXED = 2'h2,
        POS_GROUND = 2'h3
    } cei_pos_sel_e;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : cei_pkg

// [rtl/cei_edge_detect.sv]
`timescale 1ns/1ps
module cei_edge_detect
    import cei_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic level_q;

    always_ff @(posedge clk)
    begin
        if (rst)
            level_q <= 1'b0;
        else
            level_q <= level;
    end

    assign rise = level & ~level_q;
    assign fall = ~level & level_q;
endmodule : cei_edge_detect

// [rtl/cei_comparator_ctrl.sv]
`timescale 1ns/1ps
module cei_comparator_ctrl
    import cei_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic comparatorResult,
    input wire logic irqFlagClear,
    output logic comparatorIrqFlag,
    output logic [1:0] posInputSelect,
    output logic negInputSelect,
    output logic riseEdgeIrqEnable,
    output logic fallEdgeIrqEnable
);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic wrPend_q;
    logic [31:0] addr_q;
    logic [7:0] ctrl_q;
    logic riseEv;
    logic fallEv;
    logic setFlag;
    logic flag_q;
    logic result_q;
    logic takeReq;
    logic ctrlWrite;
    logic [7:0] ctrlWrData;
    logic rdCtrl;
    logic rdStatus;
    logic rdPend_q;
    cei_pos_sel_e posRoute;

    assign takeReq = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rdCtrl = (haddr == CTRL_ONE_ADDR);
    assign rdStatus = (haddr == STATUS_ADDR);
    // Control write lands at the end of its data phase
    assign ctrlWrite = wrPend_q & (addr_q == CTRL_ONE_ADDR);
    assign ctrlWrData = hwdata[7:0] & CTRL_WR_MASK;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 32'h0000_0000;
        end
        else
        begin
            wrPend_q <= takeReq & hwrite;
            rdPend_q <= takeReq & ~hwrite;
            if (takeReq)
                addr_q <= haddr;
        end
    end

    // Reserved bits masked on write, so they always read zero
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_q <= CTRL_RESET;
        else if (ctrlWrite)
            ctrl_q <= ctrlWrData;
    end

    // Read data registered at the address phase; answer in one data cycle.
    // A read right behind a control write would otherwise return the old
    // value, since that write lands on the very edge that loads hrdata.
    always_ff @(posedge clk)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (takeReq && !hwrite)
        begin
            if (rdCtrl && ctrlWrite)
                hrdata <= {24'h00_0000, ctrlWrData};
            else if (rdCtrl)
                hrdata <= {24'h00_0000, ctrl_q & CTRL_WR_MASK};
            else if (rdStatus)
                hrdata <= {30'h0000_0000, result_q, flag_q};
            else
                hrdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Edge detection and flag
    // ----------------------------------------
    cei_edge_detect i_cei_edge_detect (
        .clk(clk),
        .rst(rst),
        .level(comparatorResult),
        .rise(riseEv),
        .fall(fallEv)
    );

    assign riseEdgeIrqEnable = ctrl_q[RISE_BIT];
    assign fallEdgeIrqEnable = ctrl_q[FALL_BIT];
    assign setFlag = (riseEv & riseEdgeIrqEnable)
        | (fallEv & fallEdgeIrqEnable);

    // Set wins over a clear in the same cycle so no edge is lost
    always_ff @(posedge clk)
    begin
        if (rst)
            flag_q <= 1'b0;
        else if (setFlag)
            flag_q <= 1'b1;
        else if (irqFlagClear)
            flag_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            result_q <= 1'b0;
        else
            result_q <= comparatorResult;
    end

    assign comparatorIrqFlag = flag_q;

    // ----------------------------------------
    // Input routing
    // ----------------------------------------
    // Code 00 pin, 01 DAC level, 10 fixed level, 11 ground
    assign posRoute = cei_pos_sel_e'(ctrl_q[POS_SEL_LO +: 2]);
    assign posInputSelect = posRoute;
    assign negInputSelect = ctrl_q[NEG_SEL_BIT];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_rise;
        @(posedge clk) disable iff (rst)
        (riseEdgeIrqEnable && !$past(comparatorResult) && comparatorResult)
            |=> flag_q;
    endproperty
    a_rise: assert property (p_rise) else $error("rise edge missed");

    property p_fall;
        @(posedge clk) disable iff (rst)
        (fallEdgeIrqEnable && $past(comparatorResult) && !comparatorResult)
            |=> flag_q;
    endproperty
    a_fall: assert property (p_fall) else $error("fall edge missed");

    property p_none;
        @(posedge clk) disable iff (rst)
        (!riseEdgeIrqEnable && !fallEdgeIrqEnable && !flag_q) |=> !flag_q;
    endproperty
    a_none: assert property (p_none) else $error("flag set while disabled");

    property p_pos;
        @(posedge clk) disable iff (rst)
        ctrlWrite |=> posInputSelect == $past(hwdata[5:4]);
    endproperty
    a_pos: assert property (p_pos) else $error("positive select wrong");

    property p_neg;
        @(posedge clk) disable iff (rst)
        (wrPend_q && addr_q == CTRL_ONE_ADDR) |=> negInputSelect == $past(hwdata[0]);
    endproperty
    a_neg: assert property (p_neg) else $error("negative select wrong");

    property p_rsvd;
        @(posedge clk) disable iff (rst)
        ctrl_q[3:1] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

    property p_reset;
        @(posedge clk)
        rst |=> (ctrl_q == 8'h00 && !flag_q);
    endproperty
    a_reset: assert property (p_reset) else $error("reset not clean");

    property p_hold;
        @(posedge clk) disable iff (rst)
        (flag_q && !irqFlagClear) |=> flag_q;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");

    // ----------------------------------------
    // Checks on flag behaviour
    // ----------------------------------------
    property p_set_wins;
        @(posedge clk) disable iff (rst)
        (setFlag && irqFlagClear) |=> flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a same-cycle edge");

    property p_clear;
        @(posedge clk) disable iff (rst)
        (irqFlagClear && !setFlag) |=> !flag_q;
    endproperty
    a_clear: assert property (p_clear)
        else $error("flag not cleared");

    // Compared against the sampled past, not the detector's own history
    property p_rise_off;
        @(posedge clk) disable iff (rst)
        (!riseEdgeIrqEnable && !$past(comparatorResult) && comparatorResult && !flag_q)
            |=> !flag_q;
    endproperty
    a_rise_off: assert property (p_rise_off)
        else $error("disabled rise set the flag");

    property p_fall_off;
        @(posedge clk) disable iff (rst)
        (!fallEdgeIrqEnable && $past(comparatorResult) && !comparatorResult && !flag_q)
            |=> !flag_q;
    endproperty
    a_fall_off: assert property (p_fall_off)
        else $error("disabled fall set the flag");

    property p_only_edges;
        @(posedge clk) disable iff (rst)
        (!flag_q && !setFlag) |=> !flag_q;
    endproperty
    a_only_edges: assert property (p_only_edges)
        else $error("flag set with no enabled edge");

    property p_enables;
        @(posedge clk) disable iff (rst)
        ctrlWrite |=> (riseEdgeIrqEnable == $past(hwdata[RISE_BIT])
            && fallEdgeIrqEnable == $past(hwdata[FALL_BIT]));
    endproperty
    a_enables: assert property (p_enables)
        else $error("edge enables not written");

    property p_result;
        @(posedge clk) disable iff (rst)
        !rst |=> result_q == $past(comparatorResult);
    endproperty
    a_result: assert property (p_result)
        else $error("status result not tracking");

    // ----------------------------------------
    // Checks on the register bus
    // ----------------------------------------
    // Zero wait and always OKAY; a slower slave would need a new contract
    property p_okay;
        @(posedge clk) disable iff (rst)
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not ready and okay");

    property p_keep;
        @(posedge clk) disable iff (rst)
        !ctrlWrite |=> $stable(ctrl_q);
    endproperty
    a_keep: assert property (p_keep)
        else $error("control changed without a write");

    property p_read_ctrl;
        @(posedge clk) disable iff (rst)
        (takeReq && !hwrite && rdCtrl && !ctrlWrite) |=> hrdata[7:0] == $past(ctrl_q);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("control read data wrong");

    property p_rsvd_read;
        @(posedge clk) disable iff (rst)
        (rdPend_q && addr_q == CTRL_ONE_ADDR) |-> hrdata[3:1] == 3'h0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved bits read nonzero");

    property p_upper_zero;
        @(posedge clk) disable iff (rst)
        rdPend_q |-> hrdata[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits nonzero");

    property p_status_read;
        @(posedge clk) disable iff (rst)
        (takeReq && !hwrite && rdStatus)
            |=> hrdata[1:0] == {$past(result_q), $past(flag_q)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read data wrong");

    // Read data must stand through its data phase and beyond
    property p_hold_rdata;
        @(posedge clk) disable iff (rst)
        !(takeReq && !hwrite) |=> $stable(hrdata);
    endproperty
    a_hold_rdata: assert property (p_hold_rdata)
        else $error("read data changed without a read");

    property p_reset_out;
        @(posedge clk)
        rst |=> (!riseEdgeIrqEnable && !fallEdgeIrqEnable
            && posInputSelect == POS_PIN && !negInputSelect);
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not cleared by reset");
endmodule : cei_comparator_ctrl

// [sim/cei_comparator_ctrl_test.sv]
`timescale 1ns/1ps
module cei_comparator_ctrl_test;
    import cei_pkg::*;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, posInputSelect;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, comparatorResult = 1'b0, irqFlagClear = 1'b0;
    logic comparatorIrqFlag, negInputSelect, riseEdgeIrqEnable, fallEdgeIrqEnable;
    int miscompares = 0, n_tests = 0;
    logic [7:0] rowIn [6] = '{8'hFF, 8'h1E, 8'h20, 8'h0E, 8'h80, 8'h41};
    logic [7:0] rowOut [6] = '{8'hF1, 8'h10, 8'h20, 8'h00, 8'h80, 8'h41};
    always #2.5 clk = ~clk;
    cei_comparator_ctrl i_cei_comparator_ctrl (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .comparatorResult(comparatorResult), .irqFlagClear(irqFlagClear),
        .comparatorIrqFlag(comparatorIrqFlag), .posInputSelect(posInputSelect),
        .negInputSelect(negInputSelect), .riseEdgeIrqEnable(riseEdgeIrqEnable),
        .fallEdgeIrqEnable(fallEdgeIrqEnable));
    // Single slave: its ready is the bus ready
    assign hready = hreadyout;
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait for ready; a hang ends the run
    task waitReady;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            miscompares++;
            print_verdict();
        end
    endtask : waitReady
    task ahb(input logic wr, input logic [31:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        waitReady();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        waitReady();
        rd = hrdata;
    endtask : ahb
    function automatic logic [31:0] outs();
        return {27'h0, riseEdgeIrqEnable, fallEdgeIrqEnable, posInputSelect, negInputSelect};
    endfunction : outs
    // Arm edge enables, clear the flag, move the result, look at the flag
    task edgeCase(input logic [7:0] ctl, input logic lvl, input logic exp);
        ahb(1'b1, CTRL_ONE_ADDR, ctl);
        irqFlagClear <= 1'b1;
        @(posedge clk);
        irqFlagClear <= 1'b0;
        @(posedge clk);
        comparatorResult <= lvl;
        repeat (3) @(posedge clk);
        check(comparatorIrqFlag, exp);
        $display("Edge test ctl=%h level=%b done", ctl, lvl);
    endtask : edgeCase
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ahb(1'b0, CTRL_ONE_ADDR, 8'h00);
        check(rd, 32'h0);
        check(outs(), 32'h0);
        check(hresp, 32'h0);
        check(hreadyout, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            ahb(1'b1, CTRL_ONE_ADDR, rowIn[i]);
            ahb(1'b0, CTRL_ONE_ADDR, 8'h00);
            check(rd, {24'h0, rowOut[i]});
            check(outs(), {27'h0, rowOut[i][7:4], rowOut[i][0]});
            $display("Row %0d done", i);
        end
        edgeCase(8'h80, 1'b1, 1'b1);
        edgeCase(8'h80, 1'b0, 1'b0);
        edgeCase(8'h40, 1'b1, 1'b0);
        edgeCase(8'h40, 1'b0, 1'b1);
        edgeCase(8'h00, 1'b1, 1'b0);
        edgeCase(8'h00, 1'b0, 1'b0);
        ahb(1'b0, 32'h0000_0008, 8'h00);
        check(rd, 32'h0);
        // Edge and clear in the same cycle: the edge must win
        ahb(1'b1, CTRL_ONE_ADDR, 8'hC0);
        irqFlagClear <= 1'b1;
        comparatorResult <= 1'b1;
        @(posedge clk);
        irqFlagClear <= 1'b0;
        @(posedge clk);
        check(comparatorIrqFlag, 1'b1);
        ahb(1'b0, STATUS_ADDR, 8'h00);
        check(rd, 32'h0000_0003);
        $display("Set-over-clear and status tests done");
        ahb(1'b1, CTRL_ONE_ADDR, 8'hFF);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check(outs(), 32'h0);
        check(comparatorIrqFlag, 1'b0);
        ahb(1'b0, CTRL_ONE_ADDR, 8'h00);
        check(rd, 32'h0);
        $display("Reset and unmapped tests done");
        print_verdict();
    end
endmodule : cei_comparator_ctrl_test
